// >>> hdl/fcd_cfg.svh
// Offsets, field positions and reset values of the DMA block
`ifndef FCD_CFG_SVH
`define FCD_CFG_SVH
// Per-channel register offsets, 32-byte stride per channel
`define FCD_CH_STRIDE     8'h20
`define FCD_OFF_ADDR_A    5'h00
`define FCD_OFF_RELOAD_A  5'h04
`define FCD_OFF_ADDR_B    5'h08
`define FCD_OFF_RELOAD_B  5'h0C
`define FCD_OFF_LENGTH    5'h10
`define FCD_OFF_RELOAD_L  5'h14
`define FCD_OFF_CONTROL   5'h1C
`define FCD_OFF_STATUS    5'h1E
// Control fields
`define FCD_CTL_ENABLE    0
`define FCD_CTL_INDIRECT  1
`define FCD_CTL_DIR       2
`define FCD_CTL_WIDTH     3
`define FCD_CTL_CONT      4
`define FCD_CTL_A_WAY     5
`define FCD_CTL_A_STEP    6
`define FCD_CTL_B_WAY     7
`define FCD_CTL_B_STEP    8
`define FCD_CTL_RELOAD    9
`define FCD_CTL_TC_IE     10
`define FCD_CTL_OVR_IE    11
`define FCD_CTL_SWREQ     12
`define FCD_CTL_SECONDARY 13
// Status fields
`define FCD_ST_VALID      0
`define FCD_ST_TC         1
`define FCD_ST_OVR        2
`define FCD_ST_ACTIVE     3
// Reset values
`define FCD_CTL_RESET     16'h0000
`define FCD_ADDR_RESET    24'h000000
`define FCD_LEN_RESET     16'h0000
`endif

// >>> hdl/fcd_pkg.sv
// Types of the four-channel DMA controller
package fcd_pkg;
  typedef enum logic [2:0] {
    FCD_IDLE  = 3'b000,
    FCD_REQ   = 3'b001,
    FCD_PICK  = 3'b010,
    FCD_READ  = 3'b011,
    FCD_WRITE = 3'b100,
    FCD_FLY   = 3'b101,
    FCD_GAP   = 3'b110
  } fcd_state_t;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        wide;
    logic [23:0] addr;
    logic [15:0] wdata;
  } fcd_bus_t;
endpackage : fcd_pkg

// >>> hdl/fcd_dma.sv
// Four-channel DMA controller with AXI4-Lite register slave
//------------------------------------------------------------
//------------------------------------------------------------
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "fcd_cfg.svh"
module fcd_dma #(
  parameter int NCH = 4
) (
  input  wire logic             mclk,
  input  wire logic             srst,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire logic [NCH-1:0]   req_primary,
  input  wire logic [NCH-1:0]   req_secondary,
  output logic [NCH-1:0]        ack_primary,
  output logic [NCH-1:0]        ack_secondary,
  output logic                  bus_request,
  input  wire logic             bus_grant,
  output fcd_pkg::fcd_bus_t     bus_out,
  input  wire logic [15:0]      bus_rdata,
  output logic [NCH-1:0]        irq_level
);
  //------------------------------------------------------------
  // Request synchronisers and channel storage
  //------------------------------------------------------------
  logic [NCH-1:0] rp_s1_reg, rp_s2_reg, rs_s1_reg, rs_s2_reg;
  logic [23:0]    addr_a_counter_reg [NCH];
  logic [23:0]    reload_a_reg       [NCH];
  logic [23:0]    addr_b_counter_reg [NCH];
  logic [23:0]    reload_b_reg       [NCH];
  logic [15:0]    length_counter_reg [NCH];
  logic [15:0]    reload_l_reg       [NCH];
  logic [15:0]    channel_control_reg[NCH];
  logic [3:0]     channel_status_reg [NCH];
  fcd_pkg::fcd_state_t state_reg;
  logic [1:0]     cur_reg;
  logic [15:0]    temp_reg;
  logic           ack_on;
  logic [NCH-1:0] want;
  logic [15:0]    c;
  logic           fin;
  logic           more;
  logic [1:0]     pick;
  logic           any;
  //------------------------------------------------------------
  // Helpers
  //------------------------------------------------------------
  function automatic logic [23:0] step_addr(input logic [23:0] a, input logic step,
                                            input logic way, input logic wide);
    logic [23:0] d;
    d = wide ? 24'h000002 : 24'h000001;
    if (!step) step_addr = a;
    else if (way) step_addr = a - d;
    else step_addr = a + d;
  endfunction : step_addr
  function automatic logic ctl_of(input logic [15:0] cr, input int b);
    ctl_of = cr[b];
  endfunction : ctl_of
  //------------------------------------------------------------
  // Arbitration
  //------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      c = channel_control_reg[i];
      want[i] = c[`FCD_CTL_ENABLE] & channel_status_reg[i][`FCD_ST_ACTIVE] &
                (c[`FCD_CTL_SWREQ] | (c[`FCD_CTL_SECONDARY] ? rs_s2_reg[i] : rp_s2_reg[i]));
    end
    pick = 2'h0;
    any = 1'b0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (want[i]) begin
        pick = 2'(i);
        any = 1'b1;
      end
    end
  end
  wire [15:0] cc       = channel_control_reg[cur_reg];
  wire        indirect = ctl_of(cc, `FCD_CTL_INDIRECT);
  wire        dir      = ctl_of(cc, `FCD_CTL_DIR);
  wire        wide     = ctl_of(cc, `FCD_CTL_WIDTH);
  wire [23:0] ca       = addr_a_counter_reg[cur_reg];
  wire [23:0] cb       = addr_b_counter_reg[cur_reg];
  wire [15:0] cl       = length_counter_reg[cur_reg];
  wire        item_end = (state_reg == fcd_pkg::FCD_FLY) | (state_reg == fcd_pkg::FCD_WRITE);
  assign fin  = item_end & (cl == 16'h0001);
  assign more = want[cur_reg] & cc[`FCD_CTL_CONT] & !fin;
  //------------------------------------------------------------
  // Transfer sequencer
  //------------------------------------------------------------
  always_ff @(posedge mclk) begin
    rp_s1_reg <= req_primary;
    rp_s2_reg <= rp_s1_reg;
    rs_s1_reg <= req_secondary;
    rs_s2_reg <= rs_s1_reg;
    if (srst) begin
      state_reg <= fcd_pkg::FCD_IDLE;
      cur_reg   <= 2'h0;
      temp_reg  <= 16'h0000;
    end else begin
      unique case (state_reg)
        fcd_pkg::FCD_IDLE:  if (any) state_reg <= fcd_pkg::FCD_REQ;
        fcd_pkg::FCD_REQ:   if (bus_grant) state_reg <= fcd_pkg::FCD_PICK;
        fcd_pkg::FCD_PICK: begin
          cur_reg <= pick;
          if (!any) state_reg <= fcd_pkg::FCD_GAP;
          else state_reg <= channel_control_reg[pick][`FCD_CTL_INDIRECT] ?
                            fcd_pkg::FCD_READ : fcd_pkg::FCD_FLY;
        end
        fcd_pkg::FCD_READ: begin
          temp_reg  <= bus_rdata;
          state_reg <= fcd_pkg::FCD_WRITE;
        end
        fcd_pkg::FCD_WRITE, fcd_pkg::FCD_FLY: begin
          if (more) state_reg <= indirect ? fcd_pkg::FCD_READ : fcd_pkg::FCD_FLY;
          else state_reg <= fcd_pkg::FCD_GAP;
        end
        fcd_pkg::FCD_GAP:   state_reg <= fcd_pkg::FCD_IDLE;
        default:            state_reg <= fcd_pkg::FCD_IDLE;
      endcase
    end
  end
  assign bus_request = (state_reg != fcd_pkg::FCD_IDLE) & (state_reg != fcd_pkg::FCD_GAP);
  assign ack_on = (state_reg == fcd_pkg::FCD_FLY) |
                   ((state_reg == fcd_pkg::FCD_READ) & !dir) | ((state_reg == fcd_pkg::FCD_WRITE) & dir);
  always_comb begin
    bus_out       = '0;
    ack_primary   = '0;
    ack_secondary = '0;
    if (state_reg == fcd_pkg::FCD_FLY) begin
      bus_out = '{1'b1, dir, wide, ca, 16'h0000};
    end else if (state_reg == fcd_pkg::FCD_READ) begin
      bus_out = '{1'b1, 1'b0, wide, dir ? cb : ca, 16'h0000};
    end else if (state_reg == fcd_pkg::FCD_WRITE) begin
      bus_out = '{1'b1, 1'b1, wide, dir ? ca : cb, temp_reg};
    end
    if (ack_on && !cc[`FCD_CTL_SWREQ]) begin
      ack_primary[cur_reg]   = !cc[`FCD_CTL_SECONDARY];
      ack_secondary[cur_reg] = cc[`FCD_CTL_SECONDARY];
    end
  end
  //------------------------------------------------------------
  // AXI4-Lite slave
  //------------------------------------------------------------
  logic        bvalid_reg, rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  bresp_reg, rresp_reg;
  wire         wr_go  = s_axi_awvalid & s_axi_wvalid & !bvalid_reg;
  wire [1:0]   wch    = s_axi_awaddr[6:5];
  wire [4:0]   woff   = {s_axi_awaddr[4:2], 2'b00};
  wire [1:0]   rch    = s_axi_araddr[6:5];
  wire [4:0]   roff   = {s_axi_araddr[4:2], 2'b00};
  wire         wmap   = (s_axi_awaddr[7] == 1'b0) & (woff != 5'h18);
  wire         rmap   = (s_axi_araddr[7] == 1'b0) & (roff != 5'h18);
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = s_axi_arvalid & !rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  wire [31:0] wd = s_axi_wdata;
  always_ff @(posedge mclk) begin
    if (srst) begin
      bvalid_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      bresp_reg  <= 2'b00;
      rresp_reg  <= 2'b00;
      rdata_reg  <= 32'h00000000;
    end else begin
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wmap ? 2'b00 : 2'b10;
      end else if (s_axi_bready) bvalid_reg <= 1'b0;
      if (s_axi_arready) begin
        rvalid_reg <= 1'b1;
        rresp_reg  <= rmap ? 2'b00 : 2'b10;
        unique case (roff)
          `FCD_OFF_ADDR_A:   rdata_reg <= {8'h00, addr_a_counter_reg[rch]};
          `FCD_OFF_RELOAD_A: rdata_reg <= {8'h00, reload_a_reg[rch]};
          `FCD_OFF_ADDR_B:   rdata_reg <= {8'h00, addr_b_counter_reg[rch]};
          `FCD_OFF_RELOAD_B: rdata_reg <= {8'h00, reload_b_reg[rch]};
          `FCD_OFF_LENGTH:   rdata_reg <= {16'h0000, length_counter_reg[rch]};
          `FCD_OFF_RELOAD_L: rdata_reg <= {16'h0000, reload_l_reg[rch]};
          `FCD_OFF_CONTROL:  rdata_reg <= {12'h000, channel_status_reg[rch],
                                           channel_control_reg[rch]};
          default:           rdata_reg <= 32'h00000000;
        endcase
      end else if (s_axi_rready) rvalid_reg <= 1'b0;
    end
  end
  //------------------------------------------------------------
  // Channel registers and counters
  //------------------------------------------------------------
  always_ff @(posedge mclk) begin
    for (int i = 0; i < NCH; i++) begin
      if (srst) begin
        addr_a_counter_reg[i]  <= `FCD_ADDR_RESET;
        reload_a_reg[i]        <= `FCD_ADDR_RESET;
        addr_b_counter_reg[i]  <= `FCD_ADDR_RESET;
        reload_b_reg[i]        <= `FCD_ADDR_RESET;
        length_counter_reg[i]  <= `FCD_LEN_RESET;
        reload_l_reg[i]        <= `FCD_LEN_RESET;
        channel_control_reg[i] <= `FCD_CTL_RESET;
        channel_status_reg[i]  <= 4'h0;
      end else begin
        if (wr_go && wmap && wch == 2'(i)) begin
          unique case (woff)
            `FCD_OFF_ADDR_A:   addr_a_counter_reg[i] <= wd[23:0];
            `FCD_OFF_RELOAD_A: reload_a_reg[i] <= wd[23:0];
            `FCD_OFF_ADDR_B:   addr_b_counter_reg[i] <= wd[23:0];
            `FCD_OFF_RELOAD_B: reload_b_reg[i] <= wd[23:0];
            `FCD_OFF_LENGTH:   length_counter_reg[i] <= wd[15:0];
            `FCD_OFF_RELOAD_L: begin
              reload_l_reg[i] <= wd[15:0];
              channel_status_reg[i][`FCD_ST_VALID] <= 1'b1;
            end
            `FCD_OFF_CONTROL: begin
              if (s_axi_wstrb[1:0] != 2'b00) begin
                channel_control_reg[i] <= wd[15:0];
                channel_status_reg[i][`FCD_ST_ACTIVE] <= wd[`FCD_CTL_ENABLE];
              end
              for (int b = 0; b < 3; b++)
                if (s_axi_wstrb[2] && wd[16+b]) channel_status_reg[i][b] <= 1'b0;
            end
            default: ;
          endcase
        end
        if (item_end && cur_reg == 2'(i)) begin
          length_counter_reg[i] <= length_counter_reg[i] - 16'h0001;
          addr_a_counter_reg[i] <= step_addr(ca, cc[`FCD_CTL_A_STEP], cc[`FCD_CTL_A_WAY], wide);
          if (indirect)
            addr_b_counter_reg[i] <= step_addr(cb, cc[`FCD_CTL_B_STEP], cc[`FCD_CTL_B_WAY], wide);
          if (fin) begin
            channel_status_reg[i][`FCD_ST_TC]     <= 1'b1;
            channel_status_reg[i][`FCD_ST_OVR]    <= 1'b1;
            channel_status_reg[i][`FCD_ST_ACTIVE] <= 1'b0;
          end
        end
      end
    end
  end
  always_comb begin
    for (int i = 0; i < NCH; i++)
      irq_level[i] = (channel_status_reg[i][`FCD_ST_TC] & channel_control_reg[i][`FCD_CTL_TC_IE]) |
                     (channel_status_reg[i][`FCD_ST_OVR] & channel_control_reg[i][`FCD_CTL_OVR_IE]);
  end
endmodule : fcd_dma

// >>> sim/fcd_dma_monitor.sv
// Port checker of the DMA controller
`timescale 1ns/1ps
module fcd_dma_monitor #(
  parameter int NCH = 4
) (
  input wire logic              mclk,
  input wire logic              srst,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              bus_request,
  input wire logic              bus_grant,
  input wire fcd_pkg::fcd_bus_t bus_out,
  input wire logic [NCH-1:0]    ack_primary,
  input wire logic [NCH-1:0]    ack_secondary,
  input wire logic [NCH-1:0]    irq_level
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  reset_quiet_a: assert property ($fell(srst) |-> !bus_request && irq_level == '0
    && !s_axi_bvalid && !s_axi_rvalid) else $error("outputs busy after reset");
  bus_owned_a: assert property (bus_out.valid |-> bus_request && bus_grant)
    else $error("bus cycle without grant");
  ack_in_cycle_a: assert property (|{ack_primary, ack_secondary} |-> bus_out.valid)
    else $error("acknowledge outside bus cycle");
  ack_single_a: assert property ($onehot0({ack_primary, ack_secondary}))
    else $error("two channels acknowledged");
  write_answer_a: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
    |=> s_axi_bvalid) else $error("write response late");
  read_answer_a: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
    else $error("read response late");
  write_stands_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  read_stands_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read response dropped");
  aw_w_pair_a: assert property (s_axi_awready == s_axi_wready)
    else $error("address and data taken apart");
endmodule : fcd_dma_monitor
bind fcd_dma fcd_dma_monitor #(.NCH(NCH)) u_mon (.mclk(mclk), .srst(srst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .bus_request(bus_request), .bus_grant(bus_grant), .bus_out(bus_out),
  .ack_primary(ack_primary), .ack_secondary(ack_secondary), .irq_level(irq_level));

// >>> sim/fcd_bus_model.sv
// Bus arbiter and addressed device seen by the DMA controller
`timescale 1ns/1ps
module fcd_bus_model (
  input wire logic              mclk,
  input wire logic              srst,
  input wire logic              bus_request,
  input wire fcd_pkg::fcd_bus_t bus_out,
  input wire logic [1:0]        grant_delay,
  output logic                  bus_grant,
  output logic [15:0]           bus_rdata
);
  logic [1:0]  wait_reg;
  logic [15:0] junk_reg;
  always_ff @(posedge mclk) begin
    if (srst || !bus_request) begin
      wait_reg <= 2'h0;
      bus_grant <= 1'b0;
    end else if (wait_reg == grant_delay) begin
      bus_grant <= 1'b1;
    end else begin
      wait_reg <= wait_reg + 2'h1;
    end
  end
  always_ff @(posedge mclk) begin
    junk_reg <= srst ? 16'hA5C3 : ~junk_reg;
  end
  assign bus_rdata = (bus_out.valid && !bus_out.write) ? (bus_out.addr[15:0] ^ 16'h5A5A)
                                                        : junk_reg;
endmodule : fcd_bus_model

// >>> sim/four_channel_dma_controller_tb.sv
// Self-checking bench of the DMA controller
`timescale 1ns/1ps
module four_channel_dma_controller_tb;
  logic mclk = 1'b0, srst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid, req, gnt;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0] wstrb = 4'h0, reqp = 4'h0, reqs = 4'h0, ackp, acks, irq;
  logic [1:0] bresp, rresp, gdly = 2'h0;
  logic [15:0] brd;
  fcd_pkg::fcd_bus_t bo;
  logic [23:0] qa[$];
  logic qw[$];
  logic [15:0] qd[$];
  logic [7:0] seen;
  int n_fail = 0, comparisons = 0, run, maxrun, drops;
  always #20 mclk = ~mclk;
  fcd_dma dut (.mclk(mclk), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .req_primary(reqp), .req_secondary(reqs), .ack_primary(ackp), .ack_secondary(acks),
    .bus_request(req), .bus_grant(gnt), .bus_out(bo), .bus_rdata(brd), .irq_level(irq));
  fcd_bus_model u_bus (.mclk(mclk), .srst(srst), .bus_request(req), .bus_out(bo),
    .grant_delay(gdly), .bus_grant(gnt), .bus_rdata(brd));
  always @(posedge mclk) begin
    if (bo.valid === 1'b1) begin
      qa.push_back(bo.addr);
      qw.push_back(bo.write);
      qd.push_back(bo.wdata);
      seen = seen | {acks, ackp};
      run++;
      maxrun = (run > maxrun) ? run : maxrun;
    end else begin
      run = 0;
    end
    if (!srst && $fell(req)) drops++;
  end
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                    input logic [1:0] er);
    int t;
    @(posedge mclk);
    t = 0;
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin @(posedge mclk); t++; end while (!(awready && wready) && t < 99);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (bvalid !== 1'b1 && t < 99) begin @(posedge mclk); t++; end
    bready <= 1'b0;
    cmp("bresp", {30'h0, er}, {30'h0, bresp});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
    int t;
    @(posedge mclk);
    t = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin @(posedge mclk); t++; end while (arready !== 1'b1 && t < 99);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1 && t < 99) begin @(posedge mclk); t++; end
    rready <= 1'b0;
    v = rdata;
    cmp("rresp", {30'h0, er}, {30'h0, rresp});
  endtask : rd
  task automatic arm(input logic [7:0] b, input logic [23:0] a, input logic [23:0] bb,
                     input logic [15:0] n);
    wr(b, {8'h0, a}, 4'hF, 2'h0);
    wr(b + 8'h08, {8'h0, bb}, 4'hF, 2'h0);
    wr(b + 8'h10, {16'h0, n}, 4'hF, 2'h0);
    wr(b + 8'h1C, 32'h0007_0000, 4'h4, 2'h0);
    qa.delete();
    qw.delete();
    qd.delete();
    seen = 8'h00;
    maxrun = 0;
    drops = 0;
  endtask : arm
  task automatic wait_irq(input logic [3:0] m);
    int t;
    t = 0;
    while ((irq & m) !== m && t < 500) begin @(posedge mclk); t++; end
    repeat (4) @(posedge mclk);
  endtask : wait_irq
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    results();
  end
  initial begin
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    rd(8'h3C, 2'h0, d);
    cmp("control reset", 32'h0, d);
    rd(8'h18, 2'h2, d);
    wr(8'h80, 32'h1, 4'hF, 2'h2);
    $display("test registers done");
    arm(8'h40, 24'h000100, 24'h0, 16'h0003);
    wr(8'h5C, 32'h0451, 4'h3, 2'h0);
    reqp <= 4'h4;
    wait_irq(4'h4);
    reqp <= 4'h0;
    cmp("count", 3, qa.size());
    cmp("first addr", 32'h100, qa[0]);
    cmp("last addr", 32'h102, qa[2]);
    cmp("direction", 0, qw[0]);
    cmp("run", 3, maxrun);
    cmp("ack", 8'h04, seen);
    cmp("irq", 4'h4, irq);
    cmp("release", 0, req);
    rd(8'h5C, 2'h0, d);
    cmp("status", 4'h6, d[19:16]);
    rd(8'h50, 2'h0, d);
    cmp("length", 0, d[15:0]);
    wr(8'h5C, 32'h0007_0000, 4'h4, 2'h0);
    cmp("irq clear", 4'h0, irq);
    $display("test direct done");
    gdly <= 2'h2;
    arm(8'h60, 24'h000200, 24'h000300, 16'h0002);
    wr(8'h7C, 32'h196F, 4'h3, 2'h0);
    wait_irq(4'h8);
    wr(8'h7C, 32'h0, 4'h3, 2'h0);
    cmp("count", 4, qa.size());
    cmp("read B", 32'h300, qa[0]);
    cmp("write A", 32'h200, qa[1]);
    cmp("step B", 32'h302, qa[2]);
    cmp("step A", 32'h1FE, qa[3]);
    cmp("order", 4'b0101, {qw[0], qw[1], qw[2], qw[3]});
    cmp("data", 32'h5A, qd[1][7:0]);
    cmp("pair", 2, maxrun);
    cmp("releases", 2, drops);
    $display("test indirect done");
    gdly <= 2'h3;
    arm(8'h00, 24'h000010, 24'h0, 16'h0001);
    arm(8'h20, 24'h000020, 24'h0, 16'h0001);
    wr(8'h1C, 32'h2401, 4'h3, 2'h0);
    wr(8'h3C, 32'h0401, 4'h3, 2'h0);
    reqs <= 4'h1;
    reqp <= 4'h2;
    wait_irq(4'h3);
    reqs <= 4'h0;
    reqp <= 4'h0;
    cmp("first", 32'h10, qa[0]);
    cmp("second", 32'h20, qa[1]);
    cmp("sources", 8'h12, seen);
    $display("test priority done");
    results();
  end
endmodule : four_channel_dma_controller_tb
